/* common/adc_ctrl_params.svh */
// Functional notes
// - flush enable set: any event flushes and starts a conversion; clear: nothing happens.
// - follower converter ignores flush and start enables while follower enable is one.
// - writing one to clear bit 2 drops window monitor interrupt enable.
// - writing one to clear bit 1 drops overrun interrupt enable.
// - writing zero to a clear bit leaves that enable alone.
// - clear and set registers share one enable set; changes read back in both.
// - window monitor enable high plus its flag set raises the interrupt request.
// - positive input select is a five bit field at bits 4:0.
// - positive codes 0x00..0x0B route analog pins 0..11 in order.
// - code 0x19 picks bandgap, 0x1C picks dac; other upper codes reserved.
// - negative code 0x18 picks internal ground; 0x19..0x1F reserved.
// - start enable set: any event starts a conversion; clear: events ignored.
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

// ==========================================
// register addresses, data right-justified in lanes 0 and 1
`define OFS_EVENT_CTRL      8'h10
`define OFS_IRQ_EN_CLEAR    8'h04
`define OFS_IRQ_EN_SET      8'h18
`define OFS_IRQ_FLAG        8'h1C
`define OFS_INPUT_CTRL      8'h24
`define OFS_CTRL_C          8'h0A
`define OFS_FOLLOWER_CTRL   8'h30

// ==========================================
// field positions
`define BIT_FLUSH_EI        0
`define BIT_START_EI        1
`define BIT_IRQ_RESULT_READY   0
`define BIT_IRQ_OVERRUN        1
`define BIT_IRQ_WINDOW_MONITOR 2
`define IRQ_WIDTH           3

// ==========================================
// input codes
`define POS_SEL_PIN_LAST    5'h0B
`define POS_SEL_BANDGAP     5'h19
`define POS_SEL_DAC         5'h1C
`define NEG_SEL_PIN_LAST    5'h07
`define NEG_SEL_GND         5'h18

// ==========================================
// reset values
`define RST_EVENT_CTRL      8'h00
`define RST_IRQ_EN          3'h0
`define RST_CTRL_C          16'h0000
`define RST_INPUT_CTRL      16'h0000

`endif

/* common/adc_ctrl_pkg.sv */
package adc_ctrl_pkg;

    // decoded converter input source
    typedef enum logic [1:0] {
        SRC_NONE,
        SRC_PIN,
        SRC_BANDGAP,
        SRC_DAC
    } pos_src_t;

    typedef enum logic [1:0] {
        NSRC_NONE,
        NSRC_PIN,
        NSRC_GND
    } neg_src_t;

    // routing result towards the analog mux
    typedef struct packed {
        pos_src_t    pos_src;
        logic [11:0] pos_pin_onehot;
        neg_src_t    neg_src;
        logic [7:0]  neg_pin_onehot;
    } mux_route_t;

    // converter actions requested by events
    typedef struct packed {
        logic flush;
        logic start;
    } conv_req_t;

endpackage

/* design/adc_event_irq_input_ctrl.sv */
`timescale 1ns/1ps
`include "adc_ctrl_params.svh"

// control slice: events, interrupt enables, input selection
module adc_event_irq_input_ctrl
    import adc_ctrl_pkg::*;
#(
    parameter bit IS_FOLLOWER = 1'b1
)(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    // classic wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    output logic             o_wb_err,
    // event inputs from peripherals, same clock
    input  wire logic        i_evt_flush,
    input  wire logic        i_evt_start,
    // converter status events
    input  wire logic        i_ev_result_ready,
    input  wire logic        i_ev_overrun,
    input  wire logic        i_ev_window_monitor,
    // outputs to the converter core
    output conv_req_t        o_conv_req,
    output mux_route_t       o_route,
    output logic [15:0]      o_ctrl_c,
    output logic             o_irq
);

    // ==========================================
    // registers
    logic [7:0]            event_ctrl_q;
    logic [`IRQ_WIDTH-1:0] irq_en_q;
    logic [`IRQ_WIDTH-1:0] irq_flag_q;
    logic [15:0]           input_ctrl_q;
    logic [15:0]           ctrl_c_q;
    logic                  follower_enable_q;
    logic                  ack_q;
    logic                  err_q;
    logic [31:0]           rdata_q;
    conv_req_t             conv_req_q;

    logic                  req;
    logic                  wr;
    logic                  hit;
    logic [7:0]            wlo;
    logic [`IRQ_WIDTH-1:0] irq_events;

    // address decode, used for hit and readback
    function automatic logic mapped(input logic [7:0] adr);
        case (adr)
            `OFS_EVENT_CTRL, `OFS_IRQ_EN_CLEAR, `OFS_IRQ_EN_SET,
            `OFS_IRQ_FLAG, `OFS_INPUT_CTRL, `OFS_CTRL_C,
            `OFS_FOLLOWER_CTRL: mapped = 1'b1;
            default:            mapped = 1'b0;
        endcase
    endfunction

    // byte lane merge for 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] sel);
        merge16 = old;
        if (sel[0]) begin
            merge16[7:0] = d[7:0];
        end
        if (sel[1]) begin
            merge16[15:8] = d[15:8];
        end
    endfunction

    // ==========================================
    // bus handshake: one-cycle ack, err on unmapped
    assign req = i_wb_cyc && i_wb_stb && !ack_q && !err_q;
    assign hit = mapped(i_wb_adr);
    assign wr  = req && hit && i_wb_we;
    assign wlo = i_wb_sel[0] ? i_wb_dat[7:0] : 8'h00;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            ack_q <= req && hit;
            err_q <= req && !hit;
        end
    end

    // read data capture
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (req && hit && !i_wb_we) begin
            case (i_wb_adr)
                `OFS_EVENT_CTRL:    rdata_q <= {24'h000000, event_ctrl_q};
                `OFS_IRQ_EN_CLEAR,
                `OFS_IRQ_EN_SET:    rdata_q <= {29'h0, irq_en_q};
                `OFS_IRQ_FLAG:      rdata_q <= {29'h0, irq_flag_q};
                `OFS_INPUT_CTRL:    rdata_q <= {16'h0000, input_ctrl_q};
                `OFS_CTRL_C:        rdata_q <= {16'h0000, ctrl_c_q};
                `OFS_FOLLOWER_CTRL: rdata_q <= {31'h0, follower_enable_q};
                default:            rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================
    // plain control registers
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            event_ctrl_q      <= `RST_EVENT_CTRL;
            input_ctrl_q      <= `RST_INPUT_CTRL;
            ctrl_c_q          <= `RST_CTRL_C;
            follower_enable_q <= 1'b0;
        end else if (wr) begin
            case (i_wb_adr)
                `OFS_EVENT_CTRL:    if (i_wb_sel[0]) event_ctrl_q <= i_wb_dat[7:0];
                `OFS_INPUT_CTRL:    input_ctrl_q <= merge16(input_ctrl_q, i_wb_dat, i_wb_sel);
                `OFS_CTRL_C:        ctrl_c_q <= merge16(ctrl_c_q, i_wb_dat, i_wb_sel);
                `OFS_FOLLOWER_CTRL: if (i_wb_sel[0]) follower_enable_q <= i_wb_dat[0];
                default:            ;
            endcase
        end
    end

    // ==========================================
    // shared interrupt enables: set and clear views
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            irq_en_q <= `RST_IRQ_EN;
        end else if (wr && i_wb_adr == `OFS_IRQ_EN_CLEAR) begin
            irq_en_q <= irq_en_q & ~wlo[`IRQ_WIDTH-1:0];
        end else if (wr && i_wb_adr == `OFS_IRQ_EN_SET) begin
            irq_en_q <= irq_en_q | wlo[`IRQ_WIDTH-1:0];
        end
    end

    // ==========================================
    // sticky flags, write one to clear, set wins
    always_comb begin
        irq_events = '0;
        irq_events[`BIT_IRQ_RESULT_READY]   = i_ev_result_ready;
        irq_events[`BIT_IRQ_OVERRUN]        = i_ev_overrun;
        irq_events[`BIT_IRQ_WINDOW_MONITOR] = i_ev_window_monitor;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            irq_flag_q <= '0;
        end else if (wr && i_wb_adr == `OFS_IRQ_FLAG) begin
            irq_flag_q <= (irq_flag_q & ~wlo[`IRQ_WIDTH-1:0]) | irq_events;
        end else begin
            irq_flag_q <= irq_flag_q | irq_events;
        end
    end

    // ==========================================
    // event handling; follower ignores both enables
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            conv_req_q <= '0;
        end else begin
            conv_req_q.flush <= i_evt_flush && event_ctrl_q[`BIT_FLUSH_EI]
                                && !(IS_FOLLOWER && follower_enable_q);
            conv_req_q.start <= ((i_evt_start && event_ctrl_q[`BIT_START_EI])
                                 || (i_evt_flush && event_ctrl_q[`BIT_FLUSH_EI]))
                                && !(IS_FOLLOWER && follower_enable_q);
        end
    end

    // ==========================================
    // input routing decode
    adc_mux_decode u_mux_decode (
        .i_clk_sys  (i_clk_sys),
        .i_rst      (i_rst),
        .i_pos_code (input_ctrl_q[4:0]),
        .i_neg_code (input_ctrl_q[12:8]),
        .o_route    (o_route)
    );

    // ==========================================
    // outputs
    assign o_wb_ack   = ack_q;
    assign o_wb_err   = err_q;
    assign o_wb_dat   = rdata_q;
    assign o_conv_req = conv_req_q;
    assign o_ctrl_c   = ctrl_c_q;
    assign o_irq      = |(irq_flag_q & irq_en_q);

endmodule // adc_event_irq_input_ctrl

/* design/adc_mux_decode.sv */
`timescale 1ns/1ps
`include "adc_ctrl_params.svh"

// input code decoder, registered outputs
module adc_mux_decode
    import adc_ctrl_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic [4:0] i_pos_code,
    input  wire logic [4:0] i_neg_code,
    output mux_route_t      o_route
);

    mux_route_t route_d;
    mux_route_t route_q;

    // ==========================================
    // code decode
    always_comb begin
        route_d = '0;
        route_d.pos_src = SRC_NONE;
        if (i_pos_code <= `POS_SEL_PIN_LAST) begin
            route_d.pos_src = SRC_PIN;
            route_d.pos_pin_onehot = 12'h001 << i_pos_code[3:0];
        end else if (i_pos_code == `POS_SEL_BANDGAP) begin
            route_d.pos_src = SRC_BANDGAP;
        end else if (i_pos_code == `POS_SEL_DAC) begin
            route_d.pos_src = SRC_DAC;
        end
        route_d.neg_src = NSRC_NONE;
        if (i_neg_code <= `NEG_SEL_PIN_LAST) begin
            route_d.neg_src = NSRC_PIN;
            route_d.neg_pin_onehot = 8'h01 << i_neg_code[2:0];
        end else if (i_neg_code == `NEG_SEL_GND) begin
            route_d.neg_src = NSRC_GND;
        end
    end

    // output register
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            route_q <= '0;
        end else begin
            route_q <= route_d;
        end
    end

    assign o_route = route_q;

endmodule // adc_mux_decode

/* tb/adc_ctrl_asserts.sv */
`timescale 1ns/1ps
// ==========
// port checks of the control slice
module adc_ctrl_asserts
    import adc_ctrl_pkg::*;
(
    input wire logic        i_clk_sys,
    input wire logic        i_rst,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [7:0]  i_wb_adr,
    input wire logic [3:0]  i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic        o_wb_err,
    input wire logic        i_evt_flush,
    input wire logic        i_evt_start,
    input wire logic        i_ev_result_ready,
    input wire logic        i_ev_overrun,
    input wire logic        i_ev_window_monitor,
    input wire conv_req_t   o_conv_req,
    input wire mux_route_t  o_route,
    input wire logic        o_irq
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // write of ones to all enable-clear bits
    sequence clr_all_s;
        o_wb_ack && i_wb_we && i_wb_adr == 8'h04 && i_wb_sel[0] && i_wb_dat[2:0] == 3'h7;
    endsequence
    bus_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack && !o_wb_err |=> o_wb_ack ^ o_wb_err)
        else $error("bus request not answered");
    ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
    ack_err_a: assert property (!(o_wb_ack && o_wb_err)) else $error("ack and err together");
    flush_cause_a: assert property (o_conv_req.flush |-> $past(i_evt_flush) && o_conv_req.start)
        else $error("flush request without event");
    start_cause_a: assert property (o_conv_req.start |-> $past(i_evt_flush || i_evt_start))
        else $error("start request without event");
    irq_rise_a: assert property ($rose(o_irq) |->
        o_wb_ack || $past(i_ev_result_ready || i_ev_overrun || i_ev_window_monitor)) else $error("irq rose alone");
    clear_all_a: assert property (clr_all_s |-> !o_irq) else $error("irq after enables cleared");
    // decoder output leaves its reset value on the first edge after reset falls
    route_cause_a: assert property ($changed(o_route) |->
        $past(o_wb_ack) || $past(o_wb_ack, 2) || $past(o_wb_ack, 3) || $past(i_rst) || $past(i_rst, 2))
        else $error("route moved alone");
endmodule // adc_ctrl_asserts

bind adc_event_irq_input_ctrl adc_ctrl_asserts i_chk (.*);

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top import adc_ctrl_pkg::*;;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] dat;
    logic        ack;
    logic        err;
    logic [4:0]  ev = 5'h00;
    conv_req_t   req;
    mux_route_t  route;
    mux_route_t  e;
    logic [15:0] ctrl_c;
    logic        irq;
    logic [31:0] got;
    logic        got_err;
    int          n_mismatch = 0;
    int          n_checks = 0;

    adc_event_irq_input_ctrl #(.IS_FOLLOWER(1'b1)) i_dut (.i_clk_sys(clk), .i_rst(rst), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(dat),
        .o_wb_ack(ack), .o_wb_err(err), .i_evt_flush(ev[0]), .i_evt_start(ev[1]), .i_ev_result_ready(ev[2]),
        .i_ev_overrun(ev[3]), .i_ev_window_monitor(ev[4]), .o_conv_req(req), .o_route(route),
        .o_ctrl_c(ctrl_c), .o_irq(irq));

    // ==========
    // shared tasks
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk);
            n++;
        end while (!(ack || err) && n < 50);
        if (n >= 50) n_mismatch++;
        got = dat;
        got_err = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask

    // one-cycle event pulse, outputs settled after
    task automatic pulse(input logic [4:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 5'h00;
        #1;
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ==========
    // scenarios
    task automatic t_regs;
        wb(1'b0, 8'h18, 32'h0, 4'h1);
        chk(got, 32'h0);
        wb(1'b0, 8'h3C, 32'h0, 4'h1);
        chk({31'h0, got_err}, 32'h1);
        wb(1'b1, 8'h0A, 32'h0000A5C3, 4'h3);
        chk({16'h0, ctrl_c}, 32'h0000A5C3);
        wb(1'b0, 8'h0A, 32'h0, 4'h3);
        chk(got, 32'h0000A5C3);
        $display("regs done");
    endtask

    task automatic t_events;
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, 8'h10, i, 4'h1);
            pulse(5'h01);
            chk({30'h0, req}, {30'h0, i[0], i[0]});
            pulse(5'h02);
            chk({30'h0, req}, {31'h0, i[1]});
        end
        wb(1'b1, 8'h30, 32'h1, 4'h1);
        pulse(5'h03);
        chk({30'h0, req}, 32'h0);
        wb(1'b1, 8'h30, 32'h0, 4'h1);
        $display("events done");
    endtask

    task automatic t_irq;
        wb(1'b1, 8'h18, 32'h7, 4'h1);
        pulse(5'h10);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, 8'h04, 32'h0, 4'h1);
        wb(1'b0, 8'h18, 32'h0, 4'h1);
        chk(got, 32'h7);
        wb(1'b1, 8'h04, 32'h4, 4'h1);
        chk({31'h0, irq}, 32'h0);
        wb(1'b0, 8'h18, 32'h0, 4'h1);
        chk(got, 32'h3);
        pulse(5'h08);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, 8'h04, 32'h2, 4'h1);
        chk({31'h0, irq}, 32'h0);
        // re-enable, then drop every enable in one clear write
        wb(1'b1, 8'h18, 32'h6, 4'h1);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, 8'h04, 32'h7, 4'h1);
        chk({31'h0, irq}, 32'h0);
        wb(1'b0, 8'h18, 32'h0, 4'h1);
        chk(got, 32'h0);
        wb(1'b0, 8'h1C, 32'h0, 4'h1);
        chk(got, 32'h6);
        $display("irq done");
    endtask

    // every code on both selects
    // sampling time lives outside this block; bandgap code is only routed here
    task automatic t_mux;
        for (int c = 0; c < 32; c++) begin
            wb(1'b1, 8'h24, {19'h0, c[4:0], 3'h0, c[4:0]}, 4'h3);
            repeat (3) @(posedge clk);
            #1;
            e.pos_src = c <= 11 ? SRC_PIN : c == 25 ? SRC_BANDGAP : c == 28 ? SRC_DAC : SRC_NONE;
            e.pos_pin_onehot = c <= 11 ? 12'h001 << c : 12'h000;
            e.neg_src = c <= 7 ? NSRC_PIN : c == 24 ? NSRC_GND : NSRC_NONE;
            e.neg_pin_onehot = c <= 7 ? 8'h01 << c : 8'h00;
            chk({8'h00, route}, {8'h00, e});
        end
        $display("mux done");
    endtask

    // clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    // watchdog
    initial begin
        #100000;
        n_mismatch++;
        complete_run();
    end

    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_events();
        t_irq();
        t_mux();
        complete_run();
    end
endmodule // tb_top
